// ---- phy_pcs_line_coding.sv ----
// Line coding path: 4B/5B, scrambling, NRZI, MLT3, fiber modes, far-end fault.
// Assumes one line bit per clk_i cycle; analog slicing and clock recovery
// sit outside and deliver the line level already sampled at bit rate.
//
// Overview of operation
// - Serialise MAC nibbles into one bit stream
// - Transmit order 4B/5B, scramble, NRZI, MLT3
// - Scrambler is an 11-bit LFSR
// - Same 2047-bit sequence descrambles receive data
// - MLT3 to NRZI, NRZI edges give NRZ
// - Descramble, decode 4B/5B, deliver nibbles
// - Fiber skips scrambling and MLT3 both ways
// - Fiber bypasses autonegotiation and auto crossover
// - Signal detect gives none, fault, signal
// - Fault sends 84 ones then zero idle
// - Fault on after reset, two disable bits
// - Fiber with speed pin high forced to 100 Mb/s, set duplex
// - Fiber with speed pin low takes speed from BCR, set duplex
// - Pause only allowed with full duplex
`timescale 1ns/100ps
module phy_pcs_line_coding
  import phy_coding_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      tx_valid_i,
  input  wire logic [3:0]                tx_data_i,
  output logic                           tx_ready_o,
  output logic [1:0]                     line_o,
  input  wire logic [1:0]                line_i,
  input  wire logic [1:0]                fiber_signal_detect_in_i,
  input  wire logic                      fiber_speed_select_pin_i,
  output logic                           rx_valid_o,
  output logic [3:0]                     rx_data_o,
  output logic                           rx_dv_o,
  output phy_coding_pkg::link_mode_t     mode_o,
  input  wire phy_coding_pkg::axil_req_t axil_req_i,
  output phy_coding_pkg::axil_rsp_t      axil_rsp_o,
  output logic                           irq_o
);

  typedef struct packed {
    logic [1:0]        sd_m;
    logic [1:0]        sd_s;
    logic              spd_m;
    logic              spd_s;
    logic [1:0]        ln_m;
    logic [1:0]        ln_s;
    tx_state_t         tx_st;
    logic [4:0]        tx_sym;
    logic [2:0]        tx_bit;
    logic              tx_gap;
    logic [6:0]        fef_cnt;
    logic              nrzi_tx;
    logic [1:0]        mlt_idx;
    logic [1:0]        line;
    logic [1:0]        rx_mlt;
    logic              rx_nrzi;
    logic [9:0]        rx_sh;
    logic              rx_align;
    logic [2:0]        rx_cnt;
    logic              rx_dv;
    logic              rx_valid;
    logic [3:0]        rx_data;
    logic [3:0]        lock_cnt;
    logic              locked;
    link_mode_t        mode;
    logic              fef_act;
    logic [15:0]       bcr;
    logic [15:0]       cr4;
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_mask;
    logic              aw_ok;
    logic              w_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   tx_key;
  logic   rx_key;
  logic   scr_bit;
  logic   fef_on;
  logic   rx_load;
  logic   rx_seed;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
    case (n)
      4'h0: enc_4b5b = 5'h1e;
      4'h1: enc_4b5b = 5'h09;
      4'h2: enc_4b5b = 5'h14;
      4'h3: enc_4b5b = 5'h15;
      4'h4: enc_4b5b = 5'h0a;
      4'h5: enc_4b5b = 5'h0b;
      4'h6: enc_4b5b = 5'h0e;
      4'h7: enc_4b5b = 5'h0f;
      4'h8: enc_4b5b = 5'h12;
      4'h9: enc_4b5b = 5'h13;
      4'ha: enc_4b5b = 5'h16;
      4'hb: enc_4b5b = 5'h17;
      4'hc: enc_4b5b = 5'h1a;
      4'hd: enc_4b5b = 5'h1b;
      4'he: enc_4b5b = 5'h1c;
      default: enc_4b5b = 5'h1d;
    endcase
  endfunction : enc_4b5b

  // Returns {valid, nibble}
  function automatic logic [4:0] dec_4b5b(input logic [4:0] c);
    dec_4b5b = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (enc_4b5b(4'(i)) == c)
        dec_4b5b = {1'b1, 4'(i)};
    end
  endfunction : dec_4b5b

  function automatic logic [1:0] mlt_level(input logic [1:0] idx);
    case (idx)
      2'h1:    mlt_level = LVL_PLUS;
      2'h3:    mlt_level = LVL_MINUS;
      default: mlt_level = LVL_ZERO;
    endcase
  endfunction : mlt_level

  function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_BASIC:    reg_sel = REG_BASIC;
      OFS_CR4:      reg_sel = REG_CR4;
      OFS_STATUS:   reg_sel = REG_STATUS;
      OFS_IRQ_ST:   reg_sel = REG_IRQ_ST;
      OFS_IRQ_MASK: reg_sel = REG_IRQ_MASK;
      default:      reg_sel = REG_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d, input logic [3:0] b);
    merge16 = {b[1] ? d[15:8] : o[15:8], b[0] ? d[7:0] : o[7:0]};
  endfunction : merge16

  // ----------------------------------------------------------------
  // Keystreams
  // ----------------------------------------------------------------
  lfsr_scrambler u_tx_scr (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .load_i   (1'b0),
    .seed_i   (1'b0),
    .key_o    (tx_key)
  );

  lfsr_scrambler u_rx_descr (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .load_i   (rx_load),
    .seed_i   (rx_seed),
    .key_o    (rx_key)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       fiber;
    logic       fef_en;
    logic       boundary;
    logic       code_bit;
    logic       nrz_bit;
    logic       plain;
    logic [9:0] sh_n;
    logic [4:0] dec;
    logic       wr_go;
    logic       rd_clr;
    logic       ev_code;
    logic       ev_frame;
    fiber    = s_q.sd_s != SD_NONE;
    fef_en   = !s_q.bcr[BCR_FEF_DIS] && !s_q.cr4[CR4_FEF_DIS];
    boundary = s_q.tx_bit == SYM_LAST;
    code_bit = 1'b0;
    nrz_bit  = 1'b0;
    plain    = 1'b0;
    sh_n     = '0;
    dec      = '0;
    wr_go    = 1'b0;
    rd_clr   = 1'b0;
    ev_code  = 1'b0;
    ev_frame = 1'b0;
    s_d      = s_q;

    s_d.sd_m  = fiber_signal_detect_in_i;
    s_d.sd_s  = s_q.sd_m;
    s_d.spd_m = fiber_speed_select_pin_i;
    s_d.spd_s = s_q.spd_m;
    s_d.ln_m  = line_i;
    s_d.ln_s  = s_q.ln_m;

    // Mode resolution
    s_d.fef_act          = fiber && s_q.sd_s == SD_FAULT && fef_en;
    s_d.mode.fiber       = fiber;
    s_d.mode.signal      = s_q.sd_s[1];
    s_d.mode.an_bypass   = fiber;
    s_d.mode.mdix_off    = fiber;
    s_d.mode.speed_100   = fiber ? (s_q.spd_s || s_q.bcr[BCR_SPEED]) : s_q.bcr[BCR_SPEED];
    s_d.mode.full_duplex = s_q.bcr[BCR_DUPLEX];
    s_d.mode.pause_en    = s_q.bcr[BCR_DUPLEX] && s_q.cr4[CR4_PAUSE];

    // Transmit serialiser
    fef_on      = s_q.fef_act && s_q.tx_gap;
    code_bit    = fef_on ? (s_q.fef_cnt != FEF_ONES) : s_q.tx_sym[4];
    s_d.fef_cnt = (fef_on && s_q.fef_cnt != FEF_ONES) ? s_q.fef_cnt + 7'h1 : 7'h00;
    scr_bit     = s_q.mode.fiber ? code_bit : code_bit ^ tx_key;
    s_d.nrzi_tx = s_q.nrzi_tx ^ scr_bit;
    s_d.mlt_idx = s_q.mlt_idx + {1'b0, scr_bit};
    s_d.line    = s_q.mode.fiber ? {1'b0, s_d.nrzi_tx} : mlt_level(s_d.mlt_idx);
    s_d.tx_bit  = boundary ? 3'h0 : s_q.tx_bit + 3'h1;
    s_d.tx_sym  = {s_q.tx_sym[3:0], 1'b0};
    if (boundary)
    begin
      s_d.tx_gap = 1'b0;
      case (s_q.tx_st)
        TX_IDLE:
        begin
          if (tx_valid_i)
          begin
            s_d.tx_sym = SYM_J;
            s_d.tx_st  = TX_K;
          end
          else
          begin
            s_d.tx_sym = SYM_I;
            s_d.tx_gap = 1'b1;
          end
        end
        TX_K:
        begin
          s_d.tx_sym = SYM_K;
          s_d.tx_st  = TX_DATA;
        end
        TX_DATA:
        begin
          if (tx_valid_i)
            s_d.tx_sym = enc_4b5b(tx_data_i);
          else
          begin
            s_d.tx_sym = SYM_T;
            s_d.tx_st  = TX_R;
          end
        end
        TX_R:
        begin
          s_d.tx_sym = SYM_R;
          s_d.tx_st  = TX_IDLE;
        end
        default:
        begin
          s_d.tx_sym = SYM_I;
          s_d.tx_st  = TX_IDLE;
        end
      endcase
    end

    // Receive: line decode, descramble, align
    s_d.rx_mlt  = s_q.ln_s;
    s_d.rx_nrzi = s_q.mode.fiber ? s_q.ln_s[0] : s_q.rx_nrzi ^ (s_q.ln_s != s_q.rx_mlt);
    nrz_bit     = s_d.rx_nrzi ^ s_q.rx_nrzi;
    rx_load     = !s_q.mode.fiber && !s_q.locked;
    rx_seed     = !nrz_bit;
    plain       = s_q.mode.fiber ? nrz_bit : nrz_bit ^ rx_key;
    if (rx_load)
    begin
      s_d.lock_cnt = s_q.lock_cnt + 4'h1;
      s_d.locked   = s_q.lock_cnt == LOCK_LAST;
    end
    sh_n         = {s_q.rx_sh[8:0], plain};
    s_d.rx_sh    = sh_n;
    s_d.rx_valid = 1'b0;
    if (!s_q.rx_align)
    begin
      if (sh_n == {SYM_J, SYM_K} && (s_q.mode.fiber || s_q.locked))
      begin
        s_d.rx_align = 1'b1;
        s_d.rx_dv    = 1'b1;
        s_d.rx_cnt   = 3'h0;
        ev_frame     = 1'b1;
      end
    end
    else if (s_q.rx_cnt != SYM_LAST)
      s_d.rx_cnt = s_q.rx_cnt + 3'h1;
    else
    begin
      s_d.rx_cnt = 3'h0;
      dec        = dec_4b5b(sh_n[4:0]);
      if (dec[4])
      begin
        s_d.rx_data  = dec[3:0];
        s_d.rx_valid = 1'b1;
      end
      else
      begin
        s_d.rx_align = 1'b0;
        s_d.rx_dv    = 1'b0;
        ev_code      = sh_n[4:0] != SYM_T;
      end
    end
    if (s_q.mode.fiber && !s_q.mode.signal)
    begin
      s_d.rx_align = 1'b0;
      s_d.rx_dv    = 1'b0;
      s_d.rx_valid = 1'b0;
    end

    // Register slave
    if (axil_req_i.awvalid && !s_q.aw_ok && !s_q.bvalid)
    begin
      s_d.aw_ok   = 1'b1;
      s_d.aw_addr = axil_req_i.awaddr;
    end
    if (axil_req_i.wvalid && !s_q.w_ok && !s_q.bvalid)
    begin
      s_d.w_ok  = 1'b1;
      s_d.wdata = axil_req_i.wdata;
      s_d.wstrb = axil_req_i.wstrb;
    end
    wr_go = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
    if (wr_go)
    begin
      s_d.aw_ok  = 1'b0;
      s_d.w_ok   = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      case (reg_sel(s_q.aw_addr))
        REG_BASIC:    s_d.bcr = merge16(s_q.bcr, s_q.wdata, s_q.wstrb);
        REG_CR4:      s_d.cr4 = merge16(s_q.cr4, s_q.wdata, s_q.wstrb);
        REG_IRQ_MASK: s_d.irq_mask = s_q.wstrb[0] ? s_q.wdata[IRQ_W-1:0] : s_q.irq_mask;
        REG_NONE:     s_d.bresp = RESP_SLVERR;
        default:      s_d.bresp = RESP_OKAY;
      endcase
    end
    if (s_q.bvalid && axil_req_i.bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && axil_req_i.rready)
      s_d.rvalid = 1'b0;
    if (axil_req_i.arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      case (reg_sel(axil_req_i.araddr))
        REG_BASIC:    s_d.rdata = {16'h0000, s_q.bcr};
        REG_CR4:      s_d.rdata = {16'h0000, s_q.cr4};
        REG_STATUS:   s_d.rdata = {21'h000000, s_q.locked, s_q.rx_align, s_q.rx_dv, s_q.fef_act, s_q.mode};
        REG_IRQ_ST:
        begin
          s_d.rdata = {29'h00000000, s_q.irq_st};
          rd_clr    = 1'b1;
        end
        REG_IRQ_MASK: s_d.rdata = {29'h00000000, s_q.irq_mask};
        default:      s_d.rresp = RESP_SLVERR;
      endcase
    end

    // Sticky events; a new event beats the read clear
    s_d.irq_st            = rd_clr ? '0 : s_q.irq_st;
    s_d.irq_st[IRQ_FEF]   = s_d.irq_st[IRQ_FEF] | (s_d.fef_act && !s_q.fef_act);
    s_d.irq_st[IRQ_CODE]  = s_d.irq_st[IRQ_CODE] | ev_code;
    s_d.irq_st[IRQ_FRAME] = s_d.irq_st[IRQ_FRAME] | ev_frame;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q        <= '0;
      s_q.bcr    <= BCR_RESET;
      s_q.cr4    <= CR4_RESET;
      s_q.tx_sym <= SYM_I;
      s_q.tx_st  <= TX_IDLE;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_ready_o         = s_q.tx_bit == SYM_LAST && s_q.tx_st == TX_DATA;
  assign line_o             = s_q.line;
  assign rx_valid_o         = s_q.rx_valid;
  assign rx_data_o          = s_q.rx_data;
  assign rx_dv_o            = s_q.rx_dv;
  assign mode_o             = s_q.mode;
  assign irq_o              = |(s_q.irq_st & s_q.irq_mask);
  assign axil_rsp_o.awready = !s_q.aw_ok && !s_q.bvalid;
  assign axil_rsp_o.wready  = !s_q.w_ok && !s_q.bvalid;
  assign axil_rsp_o.bvalid  = s_q.bvalid;
  assign axil_rsp_o.bresp   = s_q.bresp;
  assign axil_rsp_o.arready = !s_q.rvalid;
  assign axil_rsp_o.rvalid  = s_q.rvalid;
  assign axil_rsp_o.rdata   = s_q.rdata;
  assign axil_rsp_o.rresp   = s_q.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_READY_ON_BOUNDARY: assert property (tx_ready_o && tx_valid_i |=> s_q.tx_sym == $past(enc_4b5b(tx_data_i)))
    else $error("nibble not loaded as 5B code");
  AST_FRAME_ORDER: assert property (s_q.tx_st == TX_K ##1 s_q.tx_st == TX_K [*4] ##1 s_q.tx_st == TX_DATA
    |-> s_q.tx_sym == SYM_K)
    else $error("start delimiter order broken");
  AST_NRZI_TOGGLE: assert property (scr_bit |=> s_q.nrzi_tx != $past(s_q.nrzi_tx))
    else $error("NRZI did not toggle on one");
  AST_MLT_HOLD: assert property (!scr_bit && $stable(s_q.mode.fiber) |=> $stable(s_q.mlt_idx) && $stable(s_q.line))
    else $error("MLT3 moved on zero");
  AST_FIBER_NO_MINUS: assert property (s_q.mode.fiber |=> line_o != LVL_MINUS)
    else $error("three-level code on fiber");
  AST_FIBER_BYPASS_AN: assert property (mode_o.fiber |-> mode_o.an_bypass && mode_o.mdix_off)
    else $error("fiber without negotiation bypass");
  AST_FAULT_DECODE: assert property (s_q.sd_s == SD_FAULT && !s_q.bcr[BCR_FEF_DIS] && !s_q.cr4[CR4_FEF_DIS]
    |=> s_q.fef_act)
    else $error("fault level not taken as far-end fault");
  AST_FEF_ZERO: assert property (fef_on && s_q.fef_cnt == FEF_ONES |-> !scr_bit ##1 s_q.fef_cnt == 7'h00)
    else $error("fault pattern zero missing");
  AST_SX_SPEED: assert property (s_q.mode.fiber && !s_q.spd_s && !s_q.bcr[BCR_SPEED] |=> !mode_o.speed_100)
    else $error("10 Mb/s fiber not forced");
  AST_PAUSE_FULL: assert property (mode_o.pause_en |-> mode_o.full_duplex)
    else $error("pause without full duplex");
  AST_RX_IN_FRAME: assert property (rx_valid_o |-> rx_dv_o && $past(s_q.rx_align))
    else $error("nibble outside frame");

  COV_TX_FRAME: cover property (s_q.tx_st == TX_R ##5 s_q.tx_st == TX_IDLE);
  COV_RX_FRAME: cover property ($rose(rx_dv_o) ##[1:200] rx_valid_o);
  COV_FEF_PATTERN: cover property (fef_on && s_q.fef_cnt == FEF_ONES);
  COV_IRQ: cover property ($rose(irq_o));

endmodule : phy_pcs_line_coding

// ---- phy_coding_pkg.sv ----
// Constants and carrier types for the port-1/port-2 line coding block.
// Assumes one serial line bit per clock cycle on both paths.
package phy_coding_pkg;

  // ----------------------------------------------------------------
  // Coding constants
  // ----------------------------------------------------------------
  localparam int unsigned LFSR_W    = 11;
  localparam int unsigned TAP_HI    = 10;
  localparam int unsigned TAP_LO    = 8;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;
  localparam logic [6:0]  FEF_ONES  = 7'h54;
  localparam logic [2:0]  SYM_LAST  = 3'h4;
  localparam logic [3:0]  LOCK_LAST = 4'ha;
  localparam logic [4:0]  SYM_I     = 5'h1f;
  localparam logic [4:0]  SYM_J     = 5'h18;
  localparam logic [4:0]  SYM_K     = 5'h11;
  localparam logic [4:0]  SYM_T     = 5'h0d;
  localparam logic [4:0]  SYM_R     = 5'h07;
  localparam logic [1:0]  LVL_ZERO  = 2'h0;
  localparam logic [1:0]  LVL_PLUS  = 2'h1;
  localparam logic [1:0]  LVL_MINUS = 2'h3;
  localparam logic [1:0]  SD_NONE   = 2'h0;
  localparam logic [1:0]  SD_FAULT  = 2'h1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned IRQ_W        = 3;
  localparam logic [7:0]  OFS_BASIC    = 8'h00;
  localparam logic [7:0]  OFS_CR4      = 8'h04;
  localparam logic [7:0]  OFS_STATUS   = 8'h08;
  localparam logic [7:0]  OFS_IRQ_ST   = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h10;
  localparam int unsigned BCR_FEF_DIS  = 2;
  localparam int unsigned BCR_DUPLEX   = 8;
  localparam int unsigned BCR_SPEED    = 13;
  localparam int unsigned CR4_PAUSE    = 4;
  localparam int unsigned CR4_FEF_DIS  = 12;
  localparam int unsigned IRQ_FEF      = 0;
  localparam int unsigned IRQ_CODE     = 1;
  localparam int unsigned IRQ_FRAME    = 2;
  localparam logic [15:0] BCR_RESET    = 16'h2100;
  localparam logic [15:0] CR4_RESET    = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {REG_BASIC, REG_CR4, REG_STATUS, REG_IRQ_ST, REG_IRQ_MASK, REG_NONE} reg_sel_t;
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic fiber;
    logic signal;
    logic an_bypass;
    logic mdix_off;
    logic speed_100;
    logic full_duplex;
    logic pause_en;
  } link_mode_t;

endpackage : phy_coding_pkg

// ---- lfsr_scrambler.sv ----
// Keystream generator shared by the transmit scrambler and receive descrambler.
// Assumes the caller XORs the key with its bits; load shifts in a seed bit.
`timescale 1ns/100ps
module lfsr_scrambler
  import phy_coding_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic load_i,
  input  wire logic seed_i,
  output logic      key_o
);

  typedef struct packed {
    logic [LFSR_W-1:0] sr;
  } lfsr_state_t;

  lfsr_state_t s_q;
  lfsr_state_t s_d;

  // ----------------------------------------------------------------
  // Feedback
  // ----------------------------------------------------------------
  assign key_o = s_q.sr[TAP_HI] ^ s_q.sr[TAP_LO];

  always_comb
  begin
    s_d = s_q;
    s_d.sr = {s_q.sr[LFSR_W-2:0], load_i ? seed_i : key_o};
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_q.sr <= LFSR_SEED;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LFSR_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !load_i |=> s_q.sr[0] == $past(s_q.sr[TAP_HI] ^ s_q.sr[TAP_LO]))
    else $error("scrambler feedback wrong");
  AST_LFSR_NONZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $past(s_q.sr) != '0 && !$past(load_i) |-> s_q.sr != '0)
    else $error("scrambler fell into all-zero lockup");

endmodule : lfsr_scrambler

// ---- line_partner.sv ----
// Far-side model: line transceiver looping transmit back to receive.
// Assumes the bench picks the detect code and the speed pin strap.
`timescale 1ns/100ps
module line_partner
(
  input  wire logic [1:0] line_i,
  input  wire logic       clk_i,
  input  wire logic [1:0] sd_sel_i,
  input  wire logic       pin_sel_i,
  output logic      [1:0] line_o,
  output logic      [1:0] sd_o,
  output logic            pin_o
);
  // One cycle of line delay
  always_ff @(posedge clk_i) line_o <= line_i;
  assign sd_o  = sd_sel_i;
  assign pin_o = pin_sel_i;
endmodule : line_partner

// ---- phy_pcs_line_coding_test.sv ----
// Self-checking bench for the line coding block.
// Assumes the line partner loops line_o back into line_i.
`timescale 1ns/100ps
module phy_pcs_line_coding_test;
  import phy_coding_pkg::*;
  logic             clk_i = 0, resetn_i = 0, tx_valid = 0, pin = 1;
  logic             tx_ready, rx_valid, rx_dv, irq, pin_w;
  logic [3:0]       tx_data = 0, rx_data;
  logic [1:0]       tx_line, rx_line, sd_w, sd_sel = 0, rr;
  link_mode_t       mode;
  axil_req_t        req = '0;
  axil_rsp_t        rsp;
  int               err_count = 0, comparisons = 0, cyc = 0, mx, h;
  logic [3:0]       rxq[$];
  logic [3:0]       nib[4] = '{4'h0, 4'h5, 4'ha, 4'hf};
  logic [31:0]      rv;

  always #12.5 clk_i = ~clk_i;

  phy_pcs_line_coding u_phy_pcs_line_coding (.clk_i(clk_i), .resetn_i(resetn_i), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(tx_ready), .line_o(tx_line), .line_i(rx_line),
    .fiber_signal_detect_in_i(sd_w), .fiber_speed_select_pin_i(pin_w), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_dv_o(rx_dv), .mode_o(mode), .axil_req_i(req), .axil_rsp_o(rsp), .irq_o(irq));
  line_partner u_line_partner (.line_i(tx_line), .clk_i(clk_i), .sd_sel_i(sd_sel), .pin_sel_i(pin),
    .line_o(rx_line), .sd_o(sd_w), .pin_o(pin_w));

  always @(negedge clk_i) if (rx_valid === 1'b1) rxq.push_back(rx_data);

  // ----
  // Tasks
  // ----
  task finish_test;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd, bd;
    logic [1:0] br;
    bd = 0;
    req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1; req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1;
    while (!bd)
    begin
      @(negedge clk_i);
      ad = req.awvalid & rsp.awready; wd = req.wvalid & rsp.wready; bd = rsp.bvalid; br = rsp.bresp;
      @(posedge clk_i);
      if (ad) req.awvalid <= 0;
      if (wd) req.wvalid <= 0;
    end
    req.bready <= 0;
    @(posedge clk_i);
    chk(32'(br), 32'(RESP_OKAY));
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at, dn;
    dn = 0;
    req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
    while (!dn)
    begin
      @(negedge clk_i);
      at = req.arvalid & rsp.arready; dn = rsp.rvalid; d = rsp.rdata; r = rsp.rresp;
      @(posedge clk_i);
      if (at) req.arvalid <= 0;
    end
    req.rready <= 0;
    @(posedge clk_i);
  endtask : rd

  task loop_chk;
    rxq.delete();
    foreach (nib[i])
    begin
      tx_valid <= 1; tx_data <= nib[i];
      do @(negedge clk_i); while (tx_ready !== 1'b1);
      @(posedge clk_i);
    end
    tx_valid <= 0;
    repeat (300) @(posedge clk_i);
    chk(32'(rxq.size()), 32'd4);
    chk(32'(rx_dv), 32'h0);
    foreach (rxq[i]) chk(32'(rxq[i]), 32'(nib[i]));
  endtask : loop_chk

  // Toggle runs between held bits of the fiber line
  task runs;
    logic p;
    int r;
    mx = 0; h = 0; r = -1;
    @(negedge clk_i) p = tx_line[0];
    repeat (400)
    begin
      @(negedge clk_i);
      if (tx_line[0] !== p)
      begin
        if (r >= 0) r++;
      end
      else
      begin
        h++;
        if (r > mx) mx = r;
        r = 0;
      end
      p = tx_line[0];
    end
    @(posedge clk_i);
  endtask : runs

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      err_count++;
      finish_test;
    end
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    rd(OFS_BASIC, rv, rr); chk(rv, {16'h0, BCR_RESET});
    rd(OFS_CR4, rv, rr); chk(rv, {16'h0, CR4_RESET});
    rd(8'h14, rv, rr); chk(32'(rr), 32'(RESP_SLVERR));
    loop_chk;
    rd(OFS_IRQ_ST, rv, rr); chk(rv, 32'h4);
    sd_sel <= 2'h2;
    repeat (5) @(posedge clk_i);
    chk(32'(mode[6:2]), 32'h1f);
    loop_chk;
    rd(OFS_STATUS, rv, rr); chk(rv, 32'h47e);
    wr(OFS_IRQ_MASK, 32'h1);
    sd_sel <= 2'h1;
    repeat (5) @(negedge clk_i);
    chk(32'(mode[6:2]), 32'h17);
    chk(32'(irq), 32'h1);
    runs; chk(mx, 84);
    rd(OFS_IRQ_ST, rv, rr); chk(32'(rv[0]), 32'h1);
    @(negedge clk_i) chk(32'(irq), 32'h0);
    @(posedge clk_i);
    wr(OFS_BASIC, 32'h2104); runs; chk(h, 0);
    wr(OFS_BASIC, 32'h2100); wr(OFS_CR4, 32'h1000); runs; chk(h, 0);
    sd_sel <= 2'h2; pin <= 0;
    wr(OFS_BASIC, 32'h0100); wr(OFS_CR4, 32'h10);
    repeat (5) @(posedge clk_i);
    chk(32'(mode[2:0]), 32'h3);
    wr(OFS_BASIC, 32'h2000);
    repeat (5) @(posedge clk_i);
    chk(32'(mode[2:0]), 32'h4);
    finish_test;
  end
endmodule : phy_pcs_line_coding_test
